//--- core/gpio_mux_pkg.sv
// package for the four-pin general-purpose i/o function block
// assumes one 50 MHz clock, synchronous active-high reset
package gpio_mux_pkg;
   // ==========================================================
   // register offsets (byte addresses on the device register port)
   localparam logic [11:0] ADDR_PIN_DIRECTION = 12'h06E;
   localparam logic [11:0] ADDR_IN_SEL_BIT2 = 12'h06F;
   localparam logic [11:0] ADDR_IN_SEL_BIT1 = 12'h070;
   localparam logic [11:0] ADDR_IN_SEL_BIT0 = 12'h071;
   localparam logic [11:0] ADDR_OUT_SEL_BIT2 = 12'h072;
   localparam logic [11:0] ADDR_OUT_SEL_BIT1 = 12'h073;
   localparam logic [11:0] ADDR_OUT_SEL_BIT0 = 12'h074;
   localparam logic [11:0] ADDR_RESERVED_SLOT = 12'h075;
   localparam logic [11:0] ADDR_PIN_OUT_VALUES = 12'h076;
   localparam logic [11:0] ADDR_PIN_IN_LEVELS = 12'h219;
   // ==========================================================
   // field layout and reset values
   localparam int PIN_COUNT = 4;
   localparam int CLK_OUT_COUNT = 8;
   localparam int HALF_CLK_OUTS = 4;
   localparam logic [3:0] DIR_RESET = 4'h0;
   localparam logic [3:0] DRIVE_RESET = 4'h0;
   localparam logic [3:0] SEL_BIT_RESET = 4'h0;
   localparam logic [3:0] RSVD_HIGH_NIBBLE = 4'h0;
   localparam int MANUAL_SEL_PIN = 2;
   // ==========================================================
   // input function codes
   localparam logic [2:0] IN_FUNC_PLAIN = 3'h0;
   localparam logic [2:0] IN_FUNC_GATE_LOW = 3'h1;
   localparam logic [2:0] IN_FUNC_GATE_HIGH = 3'h2;
   localparam logic [2:0] IN_FUNC_REF_SELECT = 3'h5;
   // output source codes
   localparam logic [2:0] OUT_SRC_DRIVE = 3'h0;
   localparam logic [2:0] OUT_SRC_FLAG_A = 3'h1;
   localparam logic [2:0] OUT_SRC_FLAG_B = 3'h2;
endpackage : gpio_mux_pkg

//--- core/gpio_sync2.sv
// two-stage synchroniser for one asynchronous level
// assumes the input is a pin level unrelated to clk_in
`default_nettype none
module gpio_sync2
   import gpio_mux_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic level_in,
   output logic level_out
);
   // ==========================================================
   // stages
   logic meta_q; // first stage, read only by the second
   logic meta_d;
   logic sync_q; // settled level
   logic sync_d;

   // next values
   always_comb begin
      meta_d = level_in;
      sync_d = meta_q;
   end

   // registers
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign level_out = sync_q;
endmodule : gpio_sync2
`default_nettype wire

//--- core/gpio_pin_slice.sv
// per-pin function decode: direction, input function, output source
// assumes synchronised pin level and registered select codes
`default_nettype none
module gpio_pin_slice
   import gpio_mux_pkg::*;
#(
   parameter bit HAS_REF_SELECT = 1'b0, // only pin 2 can steer the reference
   parameter bit HAS_FLAG_A = 1'b1, // pin 3 lacks the code-001 source
   parameter bit HAS_FLAG_B = 1'b0
) (
   input wire logic is_output_in,
   input wire logic [2:0] in_func_in,
   input wire logic [2:0] out_src_in,
   input wire logic level_in,
   input wire logic drive_in,
   input wire logic flag_a_in,
   input wire logic flag_b_in,
   output logic status_en_out,
   output logic gate_low_en_out,
   output logic gate_high_en_out,
   output logic ref_sel_en_out,
   output logic pin_value_out
);
   // ==========================================================
   // decode; reserved codes select nothing and drive low
   always_comb begin
      status_en_out = 1'b0;
      gate_low_en_out = 1'b0;
      gate_high_en_out = 1'b0;
      ref_sel_en_out = 1'b0;
      pin_value_out = 1'b0;
      if (!is_output_in) begin
         // input side
         if (in_func_in == IN_FUNC_PLAIN) begin
            status_en_out = 1'b1;
         end else if (in_func_in == IN_FUNC_GATE_LOW) begin
            gate_low_en_out = 1'b1;
         end else if (in_func_in == IN_FUNC_GATE_HIGH) begin
            gate_high_en_out = 1'b1;
         end else if (HAS_REF_SELECT && in_func_in == IN_FUNC_REF_SELECT) begin
            ref_sel_en_out = 1'b1;
         end
      end else begin
         // output side
         if (out_src_in == OUT_SRC_DRIVE) begin
            pin_value_out = drive_in;
         end else if (HAS_FLAG_A && out_src_in == OUT_SRC_FLAG_A) begin
            pin_value_out = flag_a_in;
         end else if (HAS_FLAG_B && out_src_in == OUT_SRC_FLAG_B) begin
            pin_value_out = flag_b_in;
         end
      end
   end
   // level_in kept in the port list so callers see the pin pairing
   logic unused_level;
   assign unused_level = level_in;
endmodule : gpio_pin_slice
`default_nettype wire

//--- core/gpio_function_mux.sv
// four-pin gpio function block with its control registers
// assumes a byte-wide register port with write strobe and address,
// pin levels asynchronous, status flags synchronous to clk_in
`default_nettype none
// Notes on behaviour
// - per-pin direction, zero input, resets input
// - pin 0 input: status, gate out 0/4
// - pin 1 input: status, gate out 1/5
// - pin 2 input: status, gate 2/6, ref select
// - pin 3 input: status, gate out 3/7
// - pin 0 output: drive value or loss-of-lock
// - pin 1 output: drive value or holdover
// - pin 2 output: drive, ref0 or ref1 lost
// - pin 3 output: drive value or ref1 lost
// - drive values reach gp-output pins, reset zero
// - gp-input levels readable at 0219h
module gpio_function_mux
   import gpio_mux_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [11:0] reg_addr_in, // register port address
   input wire logic reg_write_in, // one-cycle write strobe
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out, // registered read data
   input wire logic [3:0] pin_level_in, // pin input buffers
   output logic [3:0] pin_drive_out, // pin output values
   output logic [3:0] pin_oe_out, // high while driven
   input wire logic loss_of_lock_in,
   input wire logic holdover_in,
   input wire logic [1:0] ref_signal_lost_flag_in,
   input wire logic [7:0] clock_out_reg_en_in, // register output enables
   output logic [7:0] clock_out_en_out, // effective output enables
   output logic manual_ref_select_out, // synchronised select level
   output logic manual_ref_select_valid_out // pin 2 owns the select
);
   // ==========================================================
   // control registers
   logic [3:0] dir_q, dir_d;
   logic [3:0] isel2_q, isel2_d;
   logic [3:0] isel1_q, isel1_d;
   logic [3:0] isel0_q, isel0_d;
   logic [3:0] osel2_q, osel2_d;
   logic [3:0] osel1_q, osel1_d;
   logic [3:0] osel0_q, osel0_d;
   logic [3:0] drive_q, drive_d;
   logic [3:0] status_q, status_d; // captured plain-input levels
   logic [7:0] rdata_q, rdata_d;
   logic [3:0] pin_q, pin_d; // registered pin drive
   logic [7:0] clk_en_q, clk_en_d;
   logic ref_sel_q, ref_sel_d;
   logic ref_val_q, ref_val_d;

   // per-pin decode results
   logic [3:0] level_sync;
   logic [3:0] status_en;
   logic [3:0] gate_low_en;
   logic [3:0] gate_high_en;
   logic [3:0] ref_sel_en;
   logic [3:0] pin_value;
   logic [3:0] flag_a;
   logic [3:0] flag_b;

   // ==========================================================
   // flags offered per pin; unused slots tie low and are masked
   // the flags are already on clk_in, so they skip the synchronisers
   assign flag_a = {1'b0, ref_signal_lost_flag_in[0], holdover_in, loss_of_lock_in};
   assign flag_b = {ref_signal_lost_flag_in[1], ref_signal_lost_flag_in[1], 1'b0, 1'b0};

   // ==========================================================
   // pin slices
   genvar gi;
   generate
      for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
         // raw pin levels are never read before two stages
         gpio_sync2 u_sync (
            .clk_in(clk_in),
            .rst_in(rst_in),
            .level_in(pin_level_in[gi]),
            .level_out(level_sync[gi])
         );
         gpio_pin_slice #(
            .HAS_REF_SELECT(gi == MANUAL_SEL_PIN),
            .HAS_FLAG_A(gi != 3),
            .HAS_FLAG_B(gi >= 2)
         ) u_slice (
            .is_output_in(dir_q[gi]),
            .in_func_in({isel2_q[gi], isel1_q[gi], isel0_q[gi]}),
            .out_src_in({osel2_q[gi], osel1_q[gi], osel0_q[gi]}),
            .level_in(level_sync[gi]),
            .drive_in(drive_q[gi]),
            .flag_a_in(flag_a[gi]),
            .flag_b_in(flag_b[gi]),
            .status_en_out(status_en[gi]),
            .gate_low_en_out(gate_low_en[gi]),
            .gate_high_en_out(gate_high_en[gi]),
            .ref_sel_en_out(ref_sel_en[gi]),
            .pin_value_out(pin_value[gi])
         );
      end
   endgenerate

   // ==========================================================
   // register writes; reserved upper bits are simply not stored
   always_comb begin
      dir_d = dir_q;
      isel2_d = isel2_q;
      isel1_d = isel1_q;
      isel0_d = isel0_q;
      osel2_d = osel2_q;
      osel1_d = osel1_q;
      osel0_d = osel0_q;
      drive_d = drive_q;
      if (reg_write_in) begin
         if (reg_addr_in == ADDR_PIN_DIRECTION) begin
            dir_d = reg_wdata_in[3:0];
         end else if (reg_addr_in == ADDR_IN_SEL_BIT2) begin
            isel2_d = reg_wdata_in[3:0];
         end else if (reg_addr_in == ADDR_IN_SEL_BIT1) begin
            isel1_d = reg_wdata_in[3:0];
         end else if (reg_addr_in == ADDR_IN_SEL_BIT0) begin
            isel0_d = reg_wdata_in[3:0];
         end else if (reg_addr_in == ADDR_OUT_SEL_BIT2) begin
            osel2_d = reg_wdata_in[3:0];
         end else if (reg_addr_in == ADDR_OUT_SEL_BIT1) begin
            osel1_d = reg_wdata_in[3:0];
         end else if (reg_addr_in == ADDR_OUT_SEL_BIT0) begin
            osel0_d = reg_wdata_in[3:0];
         end else if (reg_addr_in == ADDR_PIN_OUT_VALUES) begin
            drive_d = reg_wdata_in[3:0];
         end
      end
   end

   // ==========================================================
   // read mux; reserved slot and unmapped addresses read zero
   always_comb begin
      rdata_d = 8'h00;
      if (reg_addr_in == ADDR_PIN_DIRECTION) begin
         rdata_d = {RSVD_HIGH_NIBBLE, dir_q};
      end else if (reg_addr_in == ADDR_IN_SEL_BIT2) begin
         rdata_d = {RSVD_HIGH_NIBBLE, isel2_q};
      end else if (reg_addr_in == ADDR_IN_SEL_BIT1) begin
         rdata_d = {RSVD_HIGH_NIBBLE, isel1_q};
      end else if (reg_addr_in == ADDR_IN_SEL_BIT0) begin
         rdata_d = {RSVD_HIGH_NIBBLE, isel0_q};
      end else if (reg_addr_in == ADDR_OUT_SEL_BIT2) begin
         rdata_d = {RSVD_HIGH_NIBBLE, osel2_q};
      end else if (reg_addr_in == ADDR_OUT_SEL_BIT1) begin
         rdata_d = {RSVD_HIGH_NIBBLE, osel1_q};
      end else if (reg_addr_in == ADDR_OUT_SEL_BIT0) begin
         rdata_d = {RSVD_HIGH_NIBBLE, osel0_q};
      end else if (reg_addr_in == ADDR_PIN_OUT_VALUES) begin
         rdata_d = {RSVD_HIGH_NIBBLE, drive_q};
      end else if (reg_addr_in == ADDR_PIN_IN_LEVELS) begin
         rdata_d = {RSVD_HIGH_NIBBLE, status_q};
      end
   end

   // ==========================================================
   // datapath next values
   always_comb begin
      // plain inputs track the pin; other pins hold their last level
      for (int i = 0; i < PIN_COUNT; i++) begin
         status_d[i] = status_en[i] ? level_sync[i] : status_q[i];
      end
      pin_d = pin_value;
      // gated outputs need the pin high and the register enable
      // an ungated output simply follows its register enable
      for (int k = 0; k < HALF_CLK_OUTS; k++) begin
         clk_en_d[k] = clock_out_reg_en_in[k] & (~gate_low_en[k] | level_sync[k]);
         clk_en_d[k + HALF_CLK_OUTS] = clock_out_reg_en_in[k + HALF_CLK_OUTS]
            & (~gate_high_en[k] | level_sync[k]);
      end
      ref_sel_d = ref_sel_en[MANUAL_SEL_PIN] & level_sync[MANUAL_SEL_PIN];
      ref_val_d = ref_sel_en[MANUAL_SEL_PIN];
   end

   // ==========================================================
   // all state registers
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         dir_q <= DIR_RESET;
         isel2_q <= SEL_BIT_RESET;
         isel1_q <= SEL_BIT_RESET;
         isel0_q <= SEL_BIT_RESET;
         osel2_q <= SEL_BIT_RESET;
         osel1_q <= SEL_BIT_RESET;
         osel0_q <= SEL_BIT_RESET;
         drive_q <= DRIVE_RESET;
         status_q <= 4'h0;
         rdata_q <= 8'h00;
         pin_q <= 4'h0;
         clk_en_q <= 8'h00;
         ref_sel_q <= 1'b0;
         ref_val_q <= 1'b0;
      end else begin
         dir_q <= dir_d;
         isel2_q <= isel2_d;
         isel1_q <= isel1_d;
         isel0_q <= isel0_d;
         osel2_q <= osel2_d;
         osel1_q <= osel1_d;
         osel0_q <= osel0_d;
         drive_q <= drive_d;
         status_q <= status_d;
         rdata_q <= rdata_d;
         pin_q <= pin_d;
         clk_en_q <= clk_en_d;
         ref_sel_q <= ref_sel_d;
         ref_val_q <= ref_val_d;
      end
   end

   // ==========================================================
   // outputs
   assign reg_rdata_out = rdata_q;
   assign pin_drive_out = pin_q;
   assign pin_oe_out = dir_q;
   assign clock_out_en_out = clk_en_q;
   assign manual_ref_select_out = ref_sel_q;
   assign manual_ref_select_valid_out = ref_val_q;

   // ==========================================================
   // assertions
   // every output is registered, so each check looks one edge past its cause
   a_dir_drives_oe: assert property (@(posedge clk_in) disable iff (rst_in)
      $past(reg_write_in) && $past(reg_addr_in) == ADDR_PIN_DIRECTION
      |-> pin_oe_out == $past(reg_wdata_in[3:0]))
      else $error("direction write not reflected on output enables");
   a_gp_out_value: assert property (@(posedge clk_in) disable iff (rst_in)
      dir_q[0] && {osel2_q[0], osel1_q[0], osel0_q[0]} == OUT_SRC_DRIVE && $stable(dir_q)
      |=> pin_drive_out[0] == $past(drive_q[0]))
      else $error("pin 0 not driven from drive value");
   a_lock_on_pin0: assert property (@(posedge clk_in) disable iff (rst_in)
      dir_q[0] && {osel2_q[0], osel1_q[0], osel0_q[0]} == OUT_SRC_FLAG_A
      |=> pin_drive_out[0] == $past(loss_of_lock_in))
      else $error("pin 0 does not show loss of lock");
   a_hold_on_pin1: assert property (@(posedge clk_in) disable iff (rst_in)
      dir_q[1] && {osel2_q[1], osel1_q[1], osel0_q[1]} == OUT_SRC_FLAG_A
      |=> pin_drive_out[1] == $past(holdover_in))
      else $error("pin 1 does not show holdover");
   a_los_on_pin2: assert property (@(posedge clk_in) disable iff (rst_in)
      dir_q[2] && {osel2_q[2], osel1_q[2], osel0_q[2]} == OUT_SRC_FLAG_B
      |=> pin_drive_out[2] == $past(ref_signal_lost_flag_in[1]))
      else $error("pin 2 does not show reference 1 loss");
   a_ref0_on_pin2: assert property (@(posedge clk_in) disable iff (rst_in)
      dir_q[2] && {osel2_q[2], osel1_q[2], osel0_q[2]} == OUT_SRC_FLAG_A
      |=> pin_drive_out[2] == $past(ref_signal_lost_flag_in[0]))
      else $error("pin 2 does not show reference 0 loss");
   a_ref1_on_pin3: assert property (@(posedge clk_in) disable iff (rst_in)
      dir_q[3] && {osel2_q[3], osel1_q[3], osel0_q[3]} == OUT_SRC_FLAG_B
      |=> pin_drive_out[3] == $past(ref_signal_lost_flag_in[1]))
      else $error("pin 3 does not show reference 1 loss");
   a_pin3_rsvd_low: assert property (@(posedge clk_in) disable iff (rst_in)
      dir_q[3] && {osel2_q[3], osel1_q[3], osel0_q[3]} == OUT_SRC_FLAG_A
      |=> !pin_drive_out[3])
      else $error("pin 3 reserved source drives high");
   a_gate_low_pin: assert property (@(posedge clk_in) disable iff (rst_in)
      !dir_q[0] && {isel2_q[0], isel1_q[0], isel0_q[0]} == IN_FUNC_GATE_LOW && !level_sync[0]
      |=> !clock_out_en_out[0])
      else $error("clock output 0 enabled with gate pin low");
   a_gate_low_pass: assert property (@(posedge clk_in) disable iff (rst_in)
      !dir_q[1] && {isel2_q[1], isel1_q[1], isel0_q[1]} == IN_FUNC_GATE_LOW && level_sync[1]
      |=> clock_out_en_out[1] == $past(clock_out_reg_en_in[1]))
      else $error("clock output 1 not following register enable");
   a_gate_high_block: assert property (@(posedge clk_in) disable iff (rst_in)
      !dir_q[2] && {isel2_q[2], isel1_q[2], isel0_q[2]} == IN_FUNC_GATE_HIGH && !level_sync[2]
      |=> !clock_out_en_out[6])
      else $error("clock output 6 enabled with gate pin low");
   a_gate_high_pass: assert property (@(posedge clk_in) disable iff (rst_in)
      !dir_q[3] && {isel2_q[3], isel1_q[3], isel0_q[3]} == IN_FUNC_GATE_HIGH && level_sync[3]
      |=> clock_out_en_out[7] == $past(clock_out_reg_en_in[7]))
      else $error("clock output 7 not following register enable");
   // two synchroniser stages and the capture put status three edges behind the pin
   a_status_two_stage: assert property (@(posedge clk_in) disable iff (rst_in)
      !$past(rst_in) && !$past(rst_in, 2)
      && !dir_q[1] && {isel2_q[1], isel1_q[1], isel0_q[1]} == IN_FUNC_PLAIN
      |=> status_q[1] == $past(pin_level_in[1], 3))
      else $error("status bit 1 not three edges behind pin");
   a_ref_sel_pin2: assert property (@(posedge clk_in) disable iff (rst_in)
      !dir_q[2] && {isel2_q[2], isel1_q[2], isel0_q[2]} == IN_FUNC_REF_SELECT
      |=> manual_ref_select_valid_out && manual_ref_select_out == $past(level_sync[2]))
      else $error("manual reference select not following pin 2");
   a_ref_sel_idle: assert property (@(posedge clk_in) disable iff (rst_in)
      !(!dir_q[2] && {isel2_q[2], isel1_q[2], isel0_q[2]} == IN_FUNC_REF_SELECT)
      |=> !manual_ref_select_valid_out && !manual_ref_select_out)
      else $error("manual reference select active without pin 2 owning it");
   a_status_read: assert property (@(posedge clk_in) disable iff (rst_in)
      reg_addr_in == ADDR_PIN_IN_LEVELS |=> reg_rdata_out == {4'h0, $past(status_q)})
      else $error("input level register read mismatch");
   // covers for the main scenarios
   c_pin3_ref1_out: cover property (@(posedge clk_in) disable iff (rst_in)
      dir_q[3] && {osel2_q[3], osel1_q[3], osel0_q[3]} == OUT_SRC_FLAG_B && ref_signal_lost_flag_in[1]);
   c_pin0_lock_out: cover property (@(posedge clk_in) disable iff (rst_in)
      dir_q[0] && {osel2_q[0], osel1_q[0], osel0_q[0]} == OUT_SRC_FLAG_A && loss_of_lock_in);
   c_gate_toggle: cover property (@(posedge clk_in) disable iff (rst_in)
      clock_out_en_out[4] ##1 !clock_out_en_out[4]);
   c_ref_select: cover property (@(posedge clk_in) disable iff (rst_in) manual_ref_select_out);
   c_status_read: cover property (@(posedge clk_in) disable iff (rst_in)
      reg_addr_in == ADDR_PIN_IN_LEVELS ##1 reg_rdata_out != 8'h00);
endmodule : gpio_function_mux
`default_nettype wire

//--- testbench/gpio_board_model.sv
// board-side model of the four gpio pins
// assumes the bench chooses the level put on pins the device leaves free
`default_nettype none
module gpio_board_model (
   input wire logic [3:0] drive_in, // device pin values
   input wire logic [3:0] oe_in, // device drives the pin when high
   input wire logic [3:0] board_level_in, // level the board puts on free pins
   output logic [3:0] wire_level_out // resolved pin level
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // pin resolution
   // a driven pin shows the device value; the board never fights it,
   // so a direction bit that fails to rise shows up as a wrong level
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wire_level_out[i] = oe_in[i] ? drive_in[i] : board_level_in[i];
      end
   end
endmodule : gpio_board_model
`default_nettype wire

//--- testbench/gpio_function_mux_test.sv
// self-checking bench for the gpio function block
// assumes the block and the board model; inputs change at falling edges
`default_nettype none
module gpio_function_mux_test;
   import gpio_mux_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // signals
   logic clk_in, rst_in, wr_q; // clock, reset, write strobe
   logic [11:0] addr;
   logic [7:0] wdata, rdata, reg_en, clk_en;
   logic [3:0] level, pin_level, pin_drive, pin_oe;
   logic lol, hold, msel, msel_v;
   logic [1:0] lost;
   int bad_count, checked, cycles;

   gpio_function_mux gpio_function_mux_inst (.clk_in(clk_in), .rst_in(rst_in),
      .reg_addr_in(addr), .reg_write_in(wr_q), .reg_wdata_in(wdata),
      .reg_rdata_out(rdata), .pin_level_in(pin_level), .pin_drive_out(pin_drive),
      .pin_oe_out(pin_oe), .loss_of_lock_in(lol), .holdover_in(hold),
      .ref_signal_lost_flag_in(lost), .clock_out_reg_en_in(reg_en),
      .clock_out_en_out(clk_en), .manual_ref_select_out(msel),
      .manual_ref_select_valid_out(msel_v));
   gpio_board_model gpio_board_model_inst (.drive_in(pin_drive), .oe_in(pin_oe),
      .board_level_in(level), .wire_level_out(pin_level));

   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end
   // ==========================================================
   // shared tasks
   task automatic end_sim();
      $display("counts: checked=%0d bad=%0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_sim

   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : check

   // strobe stays high across back-to-back writes; idle or rd drops it
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr_q = 1'b1;
      @(negedge clk_in);
   endtask : wr

   task automatic idle(input int n);
      wr_q = 1'b0;
      repeat (n) @(negedge clk_in);
   endtask : idle

   // read data is registered, so it is judged one edge after the address
   task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string what);
      wr_q = 1'b0;
      addr = a;
      @(negedge clk_in);
      check(rdata, exp, what);
   endtask : rd

   // codes packed pin 3 down to pin 0; bit b of every pin goes to one register
   task automatic codes(input logic [11:0] ic, input logic [11:0] oc);
      logic [7:0] vi, vo;
      for (int b = 2; b >= 0; b--) begin
         vi = 8'h00;
         vo = 8'h00;
         for (int p = 0; p < 4; p++) begin
            vi[p] = ic[3 * p + b];
            vo[p] = oc[3 * p + b];
         end
         wr(ADDR_IN_SEL_BIT0 - 12'(b), vi);
         wr(ADDR_OUT_SEL_BIT0 - 12'(b), vo);
      end
      idle(1);
   endtask : codes
   // ==========================================================
   // scenarios
   task automatic t_reset();
      rd(ADDR_PIN_DIRECTION, 8'h00, "dir reset");
      rd(ADDR_PIN_OUT_VALUES, 8'h00, "drive reset");
      for (int a = 0; a < 6; a++) begin
         rd(ADDR_IN_SEL_BIT2 + 12'(a), 8'h00, "select reset");
      end
      check({4'h0, pin_oe}, 8'h00, "all inputs");
      wr(ADDR_RESERVED_SLOT, 8'h00);
      wr(12'h16E, 8'h0F); // unmapped, but its low byte is the direction register's
      rd(ADDR_RESERVED_SLOT, 8'h00, "reserved slot");
      rd(12'h16E, 8'h00, "unmapped");
      rd(ADDR_PIN_DIRECTION, 8'h00, "no alias");
   endtask : t_reset

   task automatic t_dir();
      for (int p = 0; p < 4; p++) begin
         wr(ADDR_PIN_DIRECTION, 8'(1 << p));
         idle(2);
         check({4'h0, pin_oe}, 8'(1 << p), "direction");
         rd(ADDR_PIN_DIRECTION, 8'(1 << p), "dir readback");
      end
   endtask : t_dir

   task automatic t_drive();
      codes(12'h000, 12'h000);
      wr(ADDR_PIN_DIRECTION, 8'h0F);
      wr(ADDR_PIN_OUT_VALUES, 8'h0A);
      idle(3);
      check({4'h0, pin_level}, 8'h0A, "gp output");
      wr(ADDR_PIN_OUT_VALUES, 8'h05);
      rd(ADDR_PIN_OUT_VALUES, 8'h05, "drive readback");
      idle(2);
      check({4'h0, pin_drive}, 8'h05, "gp output");
   endtask : t_drive

   // flag sources ignore the drive values, which are set to all ones
   task automatic t_flags();
      wr(ADDR_PIN_OUT_VALUES, 8'h0F);
      codes(12'h000, {3'h2, 3'h1, 3'h1, 3'h1});
      for (int n = 0; n < 16; n++) begin
         {lost, hold, lol} = 4'(n);
         idle(3);
         check({4'h0, pin_drive}, {4'h0, lost[1], lost[0], hold, lol}, "flag");
      end
      codes(12'h000, {3'h1, 3'h2, 3'h7, 3'h2}); // mostly reserved sources
      {lost, hold, lol} = 4'hB;
      idle(3);
      check({4'h0, pin_drive}, 8'h04, "reserved src");
      wr(ADDR_PIN_DIRECTION, 8'h00);
      idle(2);
   endtask : t_flags

   task automatic t_gate();
      reg_en = 8'hFF;
      codes({4{3'h1}}, 12'h000);
      level = 4'h5;
      idle(4);
      check(clk_en, 8'hF5, "gate low");
      level = 4'hA;
      idle(2);
      check(clk_en, 8'hF5, "sync delay");
      idle(1);
      check(clk_en, 8'hFA, "sync done");
      codes({4{3'h2}}, 12'h000);
      level = 4'h5;
      idle(4);
      check(clk_en, 8'h5F, "gate high");
      reg_en = 8'hF0;
      idle(2);
      check(clk_en, 8'h50, "reg enable");
      reg_en = 8'hFF;
      codes({3'h3, 3'h4, 3'h3, 3'h7}, 12'h000);
      level = 4'h0;
      idle(4);
      check(clk_en, 8'hFF, "reserved in");
   endtask : t_gate

   // a pin that leaves plain input keeps its last captured level
   task automatic t_status();
      codes(12'h000, 12'h000);
      level = 4'h5;
      idle(4);
      rd(ADDR_PIN_IN_LEVELS, 8'h05, "status");
      level = 4'hA;
      idle(4);
      rd(ADDR_PIN_IN_LEVELS, 8'h0A, "status");
      codes({3'h0, 3'h0, 3'h1, 3'h0}, 12'h000);
      level = 4'h0;
      idle(4);
      rd(ADDR_PIN_IN_LEVELS, 8'h02, "status hold");
   endtask : t_status

   task automatic t_refsel();
      codes({3'h0, 3'h5, 3'h0, 3'h0}, 12'h000);
      level = 4'h4;
      idle(4);
      check({6'h00, msel_v, msel}, 8'h03, "ref select");
      level = 4'h0;
      idle(4);
      check({6'h00, msel_v, msel}, 8'h02, "ref low");
      wr(ADDR_PIN_DIRECTION, 8'h04);
      idle(3);
      check({6'h00, msel_v, msel}, 8'h00, "ref off");
   endtask : t_refsel

   // reset again with registers written, so the reset branch really shows
   task automatic t_rereset();
      rst_in = 1'b1;
      idle(3);
      check(clk_en, 8'h00, "enables in reset");
      rst_in = 1'b0;
      rd(ADDR_PIN_DIRECTION, 8'h00, "dir rereset");
      rd(ADDR_PIN_OUT_VALUES, 8'h00, "drive rereset");
      rd(ADDR_IN_SEL_BIT0, 8'h00, "select rereset");
      check({4'h0, pin_oe}, 8'h00, "inputs rereset");
   endtask : t_rereset
   // ==========================================================
   // timeout: the run needs well under a thousand cycles
   always @(posedge clk_in) begin
      cycles++;
      if (cycles >= 3000) begin
         bad_count++;
         end_sim();
      end
   end

   initial begin
      rst_in = 1'b1;
      wr_q = 1'b0;
      addr = 12'h000;
      wdata = 8'h00;
      level = 4'h0;
      {lost, hold, lol} = 4'h0;
      reg_en = 8'hFF;
      repeat (3) @(negedge clk_in);
      rst_in = 1'b0;
      t_reset();
      t_dir();
      t_drive();
      t_flags();
      t_gate();
      t_status();
      t_refsel();
      t_rereset();
      end_sim();
   end
endmodule : gpio_function_mux_test
`default_nettype wire
